/* misc_instr_defs.svh */
// Opcode, width and reset constants for the miscellaneous instruction decoder
`ifndef MISC_INSTR_DEFS_SVH
`define MISC_INSTR_DEFS_SVH

`define INSTR_W 10
`define ACC_W 4

`define OP_WRITE_LCD_CTRL1 10'h20a
`define OP_READ_LCD_CTRL1 10'h24a
`define OP_WRITE_LCD_CTRL2 10'h20b
`define OP_WRITE_CARRIER_SELECT 10'h2a8
`define OP_CARRIER_START 10'h298
`define OP_CARRIER_STOP 10'h299
`define OP_WRITE_CARRIER_OUT_CTRL 10'h2a9
`define OP_ARM_POWER_DOWN 10'h05b
`define OP_ENTER_CLOCK_RUN 10'h002
`define OP_ENTER_RAM_BACKUP 10'h008
`define OP_SKIP_IF_PD_FLAG 10'h003
`define OP_WATCHDOG_RESTART 10'h2a0
`define OP_READ_CLOCK_CTRL 10'h252
`define OP_WRITE_CLOCK_CTRL 10'h216
`define OP_READ_GP_CTRL2 10'h055
`define OP_WRITE_GP_CTRL2 10'h03e

`define RST_LCD_CTRL1 4'h0
`define RST_LCD_CTRL2 4'h0
`define RST_CARRIER_SELECT 4'h0
`define RST_CLOCK_CTRL 4'h0
`define RST_GP_CTRL2 4'h0

`endif

/* misc_instr_pkg.sv */
// Types shared by the miscellaneous instruction decoder
`default_nettype none
package misc_instr_pkg;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_WR_L1 = 5'h01,
        OP_RD_L1 = 5'h02,
        OP_WR_L2 = 5'h03,
        OP_WR_CSEL = 5'h04,
        OP_CSTART = 5'h05,
        OP_CSTOP = 5'h06,
        OP_WR_COUT = 5'h07,
        OP_ARM = 5'h08,
        OP_CLKRUN = 5'h09,
        OP_RAMBK = 5'h0a,
        OP_SKIPPD = 5'h0b,
        OP_WDRST = 5'h0c,
        OP_RD_MR = 5'h0d,
        OP_WR_MR = 5'h0e,
        OP_RD_V2 = 5'h0f,
        OP_WR_V2 = 5'h10
    } misc_op_t;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_CLOCK_RUN = 2'b01,
        PWR_RAM_BACKUP = 2'b10
    } pwr_state_t;

    typedef struct packed {
        logic [3:0] lcd_ctrl1;
        logic [3:0] lcd_ctrl2;
        logic [3:0] carrier_select;
        logic carrier_out_ctrl;
        logic carrier_run;
        logic [3:0] clock_ctrl;
        logic [3:0] gp_ctrl2;
    } periph_ctrl_t;

endpackage : misc_instr_pkg
`default_nettype wire

/* misc_op_decode.sv */
// Full ten-bit opcode decoder for the miscellaneous instruction group
`timescale 1ns/1ps
`default_nettype none
`include "misc_instr_defs.svh"

module misc_op_decode
    import misc_instr_pkg::*;
(
    input wire logic [`INSTR_W-1:0] instr, // Instruction word
    output misc_op_t op // Decoded operation
);

    always_comb begin
        case (instr)
            `OP_WRITE_LCD_CTRL1: op = OP_WR_L1;
            `OP_READ_LCD_CTRL1: op = OP_RD_L1;
            `OP_WRITE_LCD_CTRL2: op = OP_WR_L2;
            `OP_WRITE_CARRIER_SELECT: op = OP_WR_CSEL;
            `OP_CARRIER_START: op = OP_CSTART;
            `OP_CARRIER_STOP: op = OP_CSTOP;
            `OP_WRITE_CARRIER_OUT_CTRL: op = OP_WR_COUT;
            `OP_ARM_POWER_DOWN: op = OP_ARM;
            `OP_ENTER_CLOCK_RUN: op = OP_CLKRUN;
            `OP_ENTER_RAM_BACKUP: op = OP_RAMBK;
            `OP_SKIP_IF_PD_FLAG: op = OP_SKIPPD;
            `OP_WATCHDOG_RESTART: op = OP_WDRST;
            `OP_READ_CLOCK_CTRL: op = OP_RD_MR;
            `OP_WRITE_CLOCK_CTRL: op = OP_WR_MR;
            `OP_READ_GP_CTRL2: op = OP_RD_V2;
            `OP_WRITE_GP_CTRL2: op = OP_WR_V2;
            default: op = OP_NONE;
        endcase
    end

endmodule : misc_op_decode
`default_nettype wire

/* misc_instruction_decode.sv */
// Decoder and executor for the miscellaneous single-cycle instruction group
`timescale 1ns/1ps
`default_nettype none
`include "misc_instr_defs.svh"

module misc_instruction_decode
    import misc_instr_pkg::*;
(
    input wire logic clk_sys, // Instruction clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic instr_valid, // Instruction executes this cycle
    input wire logic [`INSTR_W-1:0] instr, // Instruction word
    input wire logic [`ACC_W-1:0] acc, // Accumulator contents
    input wire logic powerdown_flag, // Power-down flag from power control
    output logic acc_load, // Accumulator takes acc_load_data this cycle
    output logic [`ACC_W-1:0] acc_load_data, // Value for the accumulator
    output logic skip_next, // Skip the next instruction
    output logic group_hit, // Instruction belongs to this group
    output logic watchdog_restart, // Pulse: start watchdog timer
    output logic watchdog_timeout_clr, // Pulse: clear watchdog timeout flag
    output logic watchdog_enable_set, // Pulse: set watchdog enable flag
    output periph_ctrl_t periph, // Peripheral control register contents
    output logic core_halt, // Core clock halted
    output logic subclk_run, // Sub-clock oscillator enable
    output logic lcd_run, // LCD logic enable
    output logic timer_lc_run, // Timer LC enable
    output logic timer2_run, // Timer 2 enable
    output logic main_osc_run // Main oscillator enable
);

    misc_op_t op;
    logic exec;
    logic armed_ff;
    pwr_state_t pwr_ff;
    logic [3:0] lcd_ctrl1_ff;
    logic [3:0] lcd_ctrl2_ff;
    logic [3:0] carrier_select_ff;
    logic carrier_out_ctrl_ff;
    logic carrier_run_ff;
    logic [3:0] clock_ctrl_ff;
    logic [3:0] gp_ctrl2_ff;
    logic [3:0] nxt_acc_data;
    logic nxt_acc_load;

    misc_op_decode u_decode (
        .instr(instr),
        .op(op)
    );

    // No instruction is taken while the core is halted
    assign exec = instr_valid && (pwr_ff == PWR_RUN);
    assign group_hit = exec && (op != OP_NONE);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lcd_ctrl1_ff <= `RST_LCD_CTRL1;
            lcd_ctrl2_ff <= `RST_LCD_CTRL2;
        end else if (exec) begin
            if (op == OP_WR_L1) begin
                lcd_ctrl1_ff <= acc;
            end
            if (op == OP_WR_L2) begin
                lcd_ctrl2_ff <= acc;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            carrier_select_ff <= `RST_CARRIER_SELECT;
            carrier_out_ctrl_ff <= 1'b0;
            carrier_run_ff <= 1'b0;
        end else if (exec) begin
            case (op)
                OP_WR_CSEL: carrier_select_ff <= acc;
                OP_CSTART: carrier_run_ff <= 1'b1;
                OP_CSTOP: carrier_run_ff <= 1'b0;
                OP_WR_COUT: carrier_out_ctrl_ff <= acc[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clock_ctrl_ff <= `RST_CLOCK_CTRL;
            gp_ctrl2_ff <= `RST_GP_CTRL2;
        end else if (exec) begin
            if (op == OP_WR_MR) begin
                clock_ctrl_ff <= acc;
            end
            if (op == OP_WR_V2) begin
                gp_ctrl2_ff <= acc;
            end
        end
    end

    // Arming lasts exactly one executed instruction
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            armed_ff <= 1'b0;
        end else if (exec) begin
            armed_ff <= (op == OP_ARM);
        end
    end

    // Only reset leaves a power-down state; wake-up sources sit outside
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pwr_ff <= PWR_RUN;
        end else if (exec && armed_ff) begin
            if (op == OP_CLKRUN) begin
                pwr_ff <= PWR_CLOCK_RUN;
            end else if (op == OP_RAMBK) begin
                pwr_ff <= PWR_RAM_BACKUP;
            end
        end
    end

    // Accumulator load for the three register read transfers
    always_comb begin
        nxt_acc_load = 1'b0;
        nxt_acc_data = 4'h0;
        if (exec) begin
            case (op)
                OP_RD_L1: begin
                    nxt_acc_load = 1'b1;
                    nxt_acc_data = lcd_ctrl1_ff;
                end
                OP_RD_MR: begin
                    nxt_acc_load = 1'b1;
                    nxt_acc_data = clock_ctrl_ff;
                end
                OP_RD_V2: begin
                    nxt_acc_load = 1'b1;
                    nxt_acc_data = gp_ctrl2_ff;
                end
                default: ;
            endcase
        end
    end

    assign acc_load = nxt_acc_load;
    assign acc_load_data = nxt_acc_data;

    // Flag is only read, never written back
    assign skip_next = exec && (op == OP_SKIPPD) && powerdown_flag;

    assign watchdog_restart = exec && (op == OP_WDRST);
    assign watchdog_timeout_clr = watchdog_restart;
    assign watchdog_enable_set = watchdog_restart;

    assign periph.lcd_ctrl1 = lcd_ctrl1_ff;
    assign periph.lcd_ctrl2 = lcd_ctrl2_ff;
    assign periph.carrier_select = carrier_select_ff;
    assign periph.carrier_out_ctrl = carrier_out_ctrl_ff;
    assign periph.carrier_run = carrier_run_ff;
    assign periph.clock_ctrl = clock_ctrl_ff;
    assign periph.gp_ctrl2 = gp_ctrl2_ff;

    assign core_halt = (pwr_ff != PWR_RUN);
    assign main_osc_run = (pwr_ff == PWR_RUN);
    assign subclk_run = (pwr_ff != PWR_RAM_BACKUP);
    assign lcd_run = (pwr_ff != PWR_RAM_BACKUP);
    assign timer_lc_run = (pwr_ff != PWR_RAM_BACKUP);
    assign timer2_run = (pwr_ff != PWR_RAM_BACKUP);

endmodule : misc_instruction_decode
`default_nettype wire

/* misc_instr_checker.sv */
// Assertions on the ports of the miscellaneous instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "misc_instr_defs.svh"
module misc_instr_checker
    import misc_instr_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic reset_n, // Reset
    input wire logic instr_valid, // Executing
    input wire logic [`INSTR_W-1:0] instr, // Word
    input wire logic [`ACC_W-1:0] acc, // Accumulator
    input wire logic powerdown_flag, // Flag
    input wire logic acc_load, // Load strobe
    input wire logic [`ACC_W-1:0] acc_load_data, // Load value
    input wire logic skip_next, // Skip
    input wire logic watchdog_restart, // Pulse
    input wire logic watchdog_enable_set, // Pulse
    input wire periph_ctrl_t periph, // Registers
    input wire logic core_halt, // Halted
    input wire logic main_osc_run, // Main oscillator
    input wire logic subclk_run // Sub-clock
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire logic go = instr_valid && !core_halt;
    property p_wr_l1; go && instr == `OP_WRITE_LCD_CTRL1 |=> periph.lcd_ctrl1 == $past(acc); endproperty
    a_wr_l1: assert property (p_wr_l1) else $error("lcd_ctrl1 write lost");
    property p_rd_mr; go && instr == `OP_READ_CLOCK_CTRL |-> acc_load && acc_load_data == periph.clock_ctrl; endproperty
    a_rd_mr: assert property (p_rd_mr) else $error("clock_ctrl read wrong");
    property p_cstart; go && instr == `OP_CARRIER_START |=> periph.carrier_run; endproperty
    a_cstart: assert property (p_cstart) else $error("carrier not started");
    property p_cout; go && instr == `OP_WRITE_CARRIER_OUT_CTRL |=> periph.carrier_out_ctrl == $past(acc[0]); endproperty
    a_cout: assert property (p_cout) else $error("carrier_out_ctrl wrong");
    property p_skip; go && instr == `OP_SKIP_IF_PD_FLAG |-> skip_next == powerdown_flag; endproperty
    a_skip: assert property (p_skip) else $error("skip wrong");
    property p_wd; go && instr == `OP_WATCHDOG_RESTART |-> watchdog_restart && watchdog_enable_set; endproperty
    a_wd: assert property (p_wd) else $error("watchdog pulses missing");
    property p_pd;
        go && instr == `OP_ARM_POWER_DOWN ##1 !instr_valid ##1 go && instr == `OP_ENTER_CLOCK_RUN
        |=> core_halt && !main_osc_run && subclk_run;
    endproperty
    a_pd: assert property (p_pd) else $error("clock run mode not entered");
    property p_hold; core_halt |=> core_halt && $stable(periph); endproperty
    a_hold: assert property (p_hold) else $error("halted state changed");
endmodule : misc_instr_checker
`default_nettype wire

/* core_model.sv */
// Core-side model that holds the accumulator
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic clk_sys, // Clock
    input wire logic reset_n, // Reset
    input wire logic ld_en, // Bench preload
    input wire logic [3:0] ld_val, // Preload value
    input wire logic acc_load, // Load from block
    input wire logic [3:0] acc_load_data, // Value from block
    output logic [3:0] acc // Accumulator
);
    logic [3:0] acc_ff;
    assign acc = acc_ff;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) acc_ff <= 4'h0;
        else if (acc_load) acc_ff <= acc_load_data;
        else if (ld_en) acc_ff <= ld_val;
    end
endmodule : core_model
`default_nettype wire

/* misc_instruction_decode_tb_top.sv */
// Self-checking bench for the miscellaneous instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "misc_instr_defs.svh"
module misc_instruction_decode_tb_top;
    import misc_instr_pkg::*;
    logic clk_sys = 0, reset_n = 0, instr_valid = 0, powerdown_flag = 0, ld_en = 0;
    logic [9:0] instr = 10'h000;
    logic [3:0] acc, acc_load_data, ld_val = 4'h0;
    logic acc_load, skip_next, group_hit, wd_r, wd_c, wd_e, core_halt, sub_r, lcd_r, tlc_r, t2_r, osc_r;
    periph_ctrl_t periph;
    int err_total = 0, n_compared = 0, cyc = 0;
    logic [9:0] rd_op [3] = '{`OP_READ_LCD_CTRL1, `OP_READ_CLOCK_CTRL, `OP_READ_GP_CTRL2};
    logic [3:0] rd_exp [3] = '{4'h5, 4'hc, 4'h9};
    misc_instruction_decode uut (.clk_sys(clk_sys), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
        .acc(acc), .powerdown_flag(powerdown_flag), .acc_load(acc_load), .acc_load_data(acc_load_data),
        .skip_next(skip_next), .group_hit(group_hit), .watchdog_restart(wd_r), .watchdog_timeout_clr(wd_c),
        .watchdog_enable_set(wd_e), .periph(periph), .core_halt(core_halt), .subclk_run(sub_r), .lcd_run(lcd_r),
        .timer_lc_run(tlc_r), .timer2_run(t2_r), .main_osc_run(osc_r));
    core_model core (.clk_sys(clk_sys), .reset_n(reset_n), .ld_en(ld_en), .ld_val(ld_val), .acc_load(acc_load),
        .acc_load_data(acc_load_data), .acc(acc));
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Preload the accumulator in an idle cycle, then present op in the very next cycle
    task automatic exec(input logic [9:0] op, input logic [3:0] a);
        @(negedge clk_sys);
        instr_valid = 0;
        ld_en = 1;
        ld_val = a;
        @(negedge clk_sys);
        ld_en = 0;
        instr = op;
        instr_valid = 1;
        #1;
    endtask : exec
    task automatic idle;
        @(negedge clk_sys);
        instr_valid = 0;
        #1;
    endtask : idle
    task automatic do_reset;
        reset_n = 0;
        repeat (8) @(negedge clk_sys);
        reset_n = 1;
    endtask : do_reset
    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        do_reset;
        chk({periph, core_halt, osc_r}, 24'h1);
        exec(`OP_WRITE_LCD_CTRL1, 4'h5);
        exec(`OP_WRITE_LCD_CTRL2, 4'ha);
        exec(`OP_WRITE_CARRIER_SELECT, 4'h3);
        exec(`OP_WRITE_CLOCK_CTRL, 4'hc);
        exec(`OP_WRITE_GP_CTRL2, 4'h9);
        exec(`OP_WRITE_CARRIER_OUT_CTRL, 4'he);
        exec(`OP_CARRIER_START, 4'h0);
        idle;
        chk(periph, {4'h5, 4'ha, 4'h3, 1'b0, 1'b1, 4'hc, 4'h9});
        foreach (rd_op[i]) begin
            exec(rd_op[i], 4'h0);
            chk({acc_load, acc_load_data}, {1'b1, rd_exp[i]});
            #3;
            chk(acc, rd_exp[i]);
        end
        exec(`OP_WRITE_CARRIER_OUT_CTRL, 4'h1);
        exec(`OP_CARRIER_STOP, 4'h0);
        idle;
        chk({periph.carrier_out_ctrl, periph.carrier_run}, 2'b10);
        powerdown_flag = 1;
        exec(`OP_SKIP_IF_PD_FLAG, 4'h0);
        chk({skip_next, group_hit}, 2'b11);
        powerdown_flag = 0;
        exec(`OP_SKIP_IF_PD_FLAG, 4'h0);
        chk(skip_next, 1'b0);
        exec(`OP_WATCHDOG_RESTART, 4'h0);
        chk({wd_r, wd_c, wd_e}, 3'h7);
        exec(10'h00a, 4'h0);
        chk({group_hit, acc_load, skip_next}, 3'h0);
        exec(`OP_ENTER_CLOCK_RUN, 4'h0);
        idle;
        chk(core_halt, 1'b0);
        exec(`OP_ENTER_RAM_BACKUP, 4'h0);
        idle;
        chk({core_halt, osc_r, sub_r}, 3'b011);
        exec(`OP_ARM_POWER_DOWN, 4'h0);
        exec(10'h000, 4'h0);
        exec(`OP_ENTER_CLOCK_RUN, 4'h0);
        idle;
        chk(core_halt, 1'b0);
        exec(`OP_ARM_POWER_DOWN, 4'h0);
        exec(`OP_ENTER_CLOCK_RUN, 4'h0);
        idle;
        chk({core_halt, osc_r, sub_r, lcd_r, tlc_r, t2_r}, 6'b101111);
        exec(`OP_WRITE_LCD_CTRL1, 4'h7);
        idle;
        chk(periph.lcd_ctrl1, 4'h5);
        do_reset;
        exec(`OP_ARM_POWER_DOWN, 4'h0);
        exec(`OP_ENTER_RAM_BACKUP, 4'h0);
        idle;
        chk({core_halt, osc_r, sub_r, lcd_r, tlc_r, t2_r}, 6'b100000);
        final_report;
    end
endmodule : misc_instruction_decode_tb_top
bind misc_instruction_decode misc_instr_checker chk_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .instr_valid(instr_valid), .instr(instr), .acc(acc), .powerdown_flag(powerdown_flag), .acc_load(acc_load),
    .acc_load_data(acc_load_data), .skip_next(skip_next), .watchdog_restart(watchdog_restart),
    .watchdog_enable_set(watchdog_enable_set), .periph(periph), .core_halt(core_halt),
    .main_osc_run(main_osc_run), .subclk_run(subclk_run));
`default_nettype wire
